/* File: hdl/queue_expansion_chain_select.sv */
// token ring for the polled almost-full bus and chip code device selection
`timescale 1ns/1ps
`default_nettype none
module queue_expansion_chain_select
    import chain_select_pkg::*;
#(
    parameter int WORDS = chain_select_pkg::STATUS_WORDS
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic master_reset_n_i,
    input wire logic [chain_select_pkg::CODE_WIDTH-1:0] chip_select_code_i,
    input wire logic expansion_mode_i,
    input wire logic polled_mode_i,
    input wire logic [chain_select_pkg::STATUS_WORDS*chain_select_pkg::FLAG_BUS_WIDTH-1:0]
        status_words_i,
    input wire logic expansion_token_in_i,
    output logic expansion_token_out_o,
    output logic [chain_select_pkg::FLAG_BUS_WIDTH-1:0] almost_full_flag_bus_o,
    output logic almost_full_flag_bus_oe_o,
    output logic poll_sync_out_o,
    input wire logic [chain_select_pkg::QSEL_WIDTH-1:0] write_queue_select_i,
    input wire logic write_enable_i,
    input wire logic [chain_select_pkg::QSEL_WIDTH-1:0] read_queue_select_i,
    input wire logic read_enable_i,
    output logic write_select_hit_o,
    output logic [chain_select_pkg::QUEUE_WIDTH-1:0] write_queue_o,
    output logic read_select_hit_o,
    output logic [chain_select_pkg::QUEUE_WIDTH-1:0] read_queue_o
);
    import chain_select_pkg::*;

    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////////////
    logic mrs_n_sync; // filtered master reset level, low while resetting
    logic [CODE_WIDTH-1:0] code_sync; // filtered chip code pins
    logic mrs_active; // master reset held by the pin
    logic rst_all; // system or master reset
    logic rst_all_q; // reset of the previous cycle, for the release edge
    logic start_pulse; // first cycle after reset release
    logic [CODE_WIDTH-1:0] code_q; // chip code caught during master reset
    logic driving_q; // this device owns the flag bus
    logic [WORD_IDX_WIDTH-1:0] idx_q; // index of the word now on the bus
    logic token_q; // token pulse towards the next device
    logic [FLAG_BUS_WIDTH-1:0] bus_q; // word presented on the flag bus
    logic sync_q; // marks word one on the bus
    logic chain_mode; // token ring in use
    logic load_first; // next edge loads word one
    logic at_last; // last word now on the bus

    // pick one status word out of the flat input
    function automatic logic [FLAG_BUS_WIDTH-1:0] word_at(
        input logic [STATUS_WORDS*FLAG_BUS_WIDTH-1:0] words,
        input logic [WORD_IDX_WIDTH-1:0] idx
    );
        word_at = words[idx*FLAG_BUS_WIDTH +: FLAG_BUS_WIDTH];
    endfunction

    // device field of a queue address against the held code
    function automatic logic code_match(
        input logic [QSEL_WIDTH-1:0] addr,
        input logic [CODE_WIDTH-1:0] code
    );
        code_match = (addr[DEV_MSB:DEV_LSB] == code);
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // pin synchronisers and reset
    ////////////////////////////////////////////////////////////////////////////////
    // master reset arrives from a pin, so it is filtered before use
    pin_sync3 #(
        .WIDTH(1),
        .INIT(1'b0)
    ) u_mrs_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(master_reset_n_i),
        .level_o(mrs_n_sync)
    );

    // code pins are static straps but still come from outside
    pin_sync3 #(
        .WIDTH(CODE_WIDTH),
        .INIT(CODE_RESET)
    ) u_code_sync (
        .sys_clk_i(sys_clk_i),
        .sys_rst_i(sys_rst_i),
        .pin_i(chip_select_code_i),
        .level_o(code_sync)
    );

    assign mrs_active = !mrs_n_sync;
    assign rst_all = sys_rst_i || mrs_active;

    // remember reset to find the release edge
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            rst_all_q <= 1'b1;
        end else begin
            rst_all_q <= rst_all;
        end
    end
    assign start_pulse = rst_all_q && !rst_all;

    // catch the code while master reset is held; it is frozen afterwards,
    // so a pin that toggles later cannot move the device in the address map
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            code_q <= CODE_RESET;
        end else if (mrs_active) begin
            code_q <= code_sync;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // polled flag bus and token ring
    ////////////////////////////////////////////////////////////////////////////////
    assign chain_mode = expansion_mode_i && polled_mode_i;
    assign at_last = (idx_q == WORD_LAST);
    // the master starts the ring; a lone device starts whatever its code
    // token input is same-clock logic of the neighbour, so it is not filtered
    // a token that lands on the last word is taken, so a ring looped back onto
    // this device alone keeps polling; mid-burst tokens are still ignored
    assign load_first = polled_mode_i && (!driving_q || at_last) &&
        ((start_pulse && (!expansion_mode_i || code_q == MASTER_CODE)) ||
        (chain_mode && expansion_token_in_i));

    // ownership and word index
    always_ff @(posedge sys_clk_i) begin
        if (rst_all || !polled_mode_i) begin
            driving_q <= 1'b0;
            idx_q <= WORD_FIRST;
        end else if (load_first) begin
            driving_q <= 1'b1;
            idx_q <= WORD_FIRST;
        end else if (driving_q && at_last) begin
            // in a chain the bus is handed on; alone the device wraps
            driving_q <= !expansion_mode_i;
            idx_q <= WORD_FIRST;
        end else if (driving_q) begin
            idx_q <= idx_q + WORD_STEP;
        end
    end

    // word data and sync marker follow the index being loaded
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            bus_q <= FLAG_BUS_RESET;
            sync_q <= 1'b0;
        end else if (load_first || (driving_q && at_last && !expansion_mode_i)) begin
            bus_q <= word_at(status_words_i, WORD_FIRST);
            sync_q <= 1'b1;
        end else if (driving_q && !at_last) begin
            bus_q <= word_at(status_words_i, idx_q + WORD_STEP);
            sync_q <= 1'b0;
        end else begin
            sync_q <= 1'b0;
        end
    end

    // token set while the last word goes out; one cycle only, so the
    // neighbour takes the bus on the very edge this device lets go
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            token_q <= 1'b0;
        end else begin
            token_q <= chain_mode && driving_q && !load_first &&
                (idx_q == WORD_LAST - WORD_STEP);
        end
    end

    assign expansion_token_out_o = token_q;
    assign almost_full_flag_bus_o = bus_q;
    assign almost_full_flag_bus_oe_o = driving_q;
    assign poll_sync_out_o = sync_q;

    ////////////////////////////////////////////////////////////////////////////////
    // device selection on the queue address buses
    ////////////////////////////////////////////////////////////////////////////////
    // write side: hit only when the device field equals the held code
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            write_select_hit_o <= 1'b0;
            write_queue_o <= QUEUE_RESET;
        end else begin
            write_select_hit_o <= write_enable_i &&
                code_match(write_queue_select_i, code_q);
            write_queue_o <= write_queue_select_i[QUEUE_WIDTH-1:0];
        end
    end

    // read side mirrors the write side
    always_ff @(posedge sys_clk_i) begin
        if (rst_all) begin
            read_select_hit_o <= 1'b0;
            read_queue_o <= QUEUE_RESET;
        end else begin
            read_select_hit_o <= read_enable_i &&
                code_match(read_queue_select_i, code_q);
            read_queue_o <= read_queue_select_i[QUEUE_WIDTH-1:0];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // assertions and covers
    ////////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge sys_clk_i); endclocking
    default disable iff (rst_all);

    a_token_single_cycle: assert property (
        token_q |=> !token_q)
        else $error("token pulse longer than one cycle");

    a_token_last_word: assert property (
        token_q |-> driving_q && at_last)
        else $error("token out while last word not on bus");

    a_token_mode_gate: assert property (
        token_q |-> $past(chain_mode))
        else $error("token out outside polled expansion");

    a_token_loads_first: assert property (
        (chain_mode && expansion_token_in_i && !driving_q) |=>
        (driving_q && idx_q == WORD_FIRST && sync_q))
        else $error("token receipt did not load word one");

    a_word_advance: assert property (
        (polled_mode_i && driving_q && !at_last) |=> (idx_q == $past(idx_q) + WORD_STEP))
        else $error("status word index did not advance");

    a_lone_wrap: assert property (
        (polled_mode_i && !expansion_mode_i && driving_q && at_last) ##1 polled_mode_i
        |-> driving_q && idx_q == WORD_FIRST)
        else $error("lone device did not wrap to word one");

    a_chain_release: assert property (
        (chain_mode && driving_q && at_last && !expansion_token_in_i) |=> !driving_q)
        else $error("device kept bus after its last word");

    a_sync_marker: assert property (
        driving_q && $past(driving_q || load_first) |-> (sync_q == (idx_q == WORD_FIRST)))
        else $error("sync marker wrong for shown word");

    a_write_select: assert property (
        write_select_hit_o |-> $past(write_enable_i) &&
        $past(write_queue_select_i[DEV_MSB:DEV_LSB]) == code_q)
        else $error("write hit without code match");

    a_read_select: assert property (
        (read_enable_i && code_match(read_queue_select_i, code_q)) |=> read_select_hit_o)
        else $error("read select missed matching code");

    a_code_hold: assert property (
        !mrs_active ##1 !mrs_active |-> code_q == $past(code_q))
        else $error("chip code changed outside master reset");

    c_token_out: cover property (driving_q && at_last ##1 token_q);
    c_token_in_load: cover property (expansion_token_in_i && !driving_q ##1 sync_q);
    c_lone_wrap: cover property (!expansion_mode_i && driving_q && at_last ##1 sync_q);
    c_read_hit: cover property (read_select_hit_o);
endmodule
`default_nettype wire

/* File: shared/chain_select_pkg.sv */
// constants shared by the chain select block and its testbench
package chain_select_pkg;
    // clock period of the system clock, in ns
    localparam int CLK_PERIOD_NS = 100;
    // queue select bus layout
    localparam int QSEL_WIDTH = 8;
    localparam int DEV_MSB = 7;
    localparam int DEV_LSB = 5;
    localparam int CODE_WIDTH = DEV_MSB - DEV_LSB + 1;
    localparam int QUEUE_WIDTH = DEV_LSB;
    // almost-full status bus layout
    localparam int FLAG_BUS_WIDTH = 8;
    localparam int STATUS_WORDS = 4;
    localparam int WORD_IDX_WIDTH = 2;
    // code of the master or lone device
    localparam logic [CODE_WIDTH-1:0] MASTER_CODE = 3'h0;
    // reset values and word index limits
    localparam logic [CODE_WIDTH-1:0] CODE_RESET = 3'h0;
    localparam logic [FLAG_BUS_WIDTH-1:0] FLAG_BUS_RESET = 8'h00;
    localparam logic [QUEUE_WIDTH-1:0] QUEUE_RESET = 5'h00;
    localparam logic [WORD_IDX_WIDTH-1:0] WORD_FIRST = 2'h0;
    localparam logic [WORD_IDX_WIDTH-1:0] WORD_LAST = 2'h3;
    localparam logic [WORD_IDX_WIDTH-1:0] WORD_STEP = 2'h1;
endpackage

/* File: hdl/pin_sync3.sv */
// three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
`default_nettype none
module pin_sync3 #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] INIT = '0
) (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);
    logic [WIDTH-1:0] meta_q; // first stage, read only by the second
    logic [WIDTH-1:0] stage2_q; // second stage
    logic [WIDTH-1:0] stage3_q; // third stage

    // shift chain; the first stage feeds nothing but the second
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            meta_q <= INIT;
            stage2_q <= INIT;
            stage3_q <= INIT;
        end else begin
            meta_q <= pin_i;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    // a change counts only once stages two and three agree
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            level_o <= INIT;
        end else if (stage2_q == stage3_q) begin
            level_o <= stage3_q;
        end
    end
endmodule
`default_nettype wire

/* File: sim/chain_neighbour_model.sv */
// next device in the token ring: holds the token for its own poll words, then passes it back
`timescale 1ns/1ps
`default_nettype none
module chain_neighbour_model (
    input wire logic sys_clk_i,
    input wire logic sys_rst_i,
    input wire logic token_i,
    input wire logic [3:0] hold_i,
    input wire logic inject_i,
    output logic token_o
);
    // cycles left before the token goes back, zero when idle
    logic [3:0] left_q;
    ////////////////////////////////////////////////////////////////
    // load the hold time on receipt; 1 answers promptly, larger values slowly
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            left_q <= 4'h0;
        end else if (token_i) begin
            left_q <= hold_i;
        end else if (left_q != 4'h0) begin
            left_q <= left_q - 4'h1;
        end
    end
    // registered one-cycle token; inject fires only when a scenario wants a stray token
    always_ff @(posedge sys_clk_i) begin
        if (sys_rst_i) begin
            token_o <= 1'h0;
        end else begin
            token_o <= (left_q == 4'h1) | inject_i;
        end
    end
endmodule
`default_nettype wire

/* File: sim/test_queue_expansion_chain_select.sv */
// self-checking bench for the chain select block with a neighbour closing the ring
`timescale 1ns/1ps
`default_nettype none
module test_queue_expansion_chain_select;
    import chain_select_pkg::*;
    // word1 sits in the low byte
    localparam logic [31:0] WORDS_V = 32'hD4C3B2A1;
    logic sys_clk_i = 1'h0;
    logic sys_rst_i = 1'h1;
    logic mrs_n = 1'h0;
    logic [2:0] code = 3'h0;
    logic exp_mode = 1'h0;
    logic polled = 1'h0;
    logic tok_in, tok_out, oe, sync, w_hit, r_hit;
    logic [7:0] bus;
    logic [7:0] w_sel = 8'h00;
    logic [7:0] r_sel = 8'h00;
    logic we = 1'h0;
    logic re = 1'h0;
    logic inject = 1'h0;
    logic [4:0] w_q, r_q;
    logic [3:0] hold = 4'h1;
    int n_fail = 0;
    int n_checks = 0;
    ////////////////////////////////////////////////////////////////
    // clock and the two parties
    always #(CLK_PERIOD_NS / 2) sys_clk_i = ~sys_clk_i;
    queue_expansion_chain_select DUT (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .master_reset_n_i(mrs_n),
        .chip_select_code_i(code), .expansion_mode_i(exp_mode), .polled_mode_i(polled),
        .status_words_i(WORDS_V), .expansion_token_in_i(tok_in),
        .expansion_token_out_o(tok_out), .almost_full_flag_bus_o(bus),
        .almost_full_flag_bus_oe_o(oe), .poll_sync_out_o(sync),
        .write_queue_select_i(w_sel), .write_enable_i(we), .read_queue_select_i(r_sel),
        .read_enable_i(re), .write_select_hit_o(w_hit), .write_queue_o(w_q),
        .read_select_hit_o(r_hit), .read_queue_o(r_q)
    );
    // ring closes through the neighbour
    chain_neighbour_model neighbour (
        .sys_clk_i(sys_clk_i), .sys_rst_i(sys_rst_i), .token_i(tok_out),
        .hold_i(hold), .inject_i(inject), .token_o(tok_in)
    );
    ////////////////////////////////////////////////////////////////
    // shared helpers
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_fail++;
            $display("FAIL %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // pins settle through the filters, so the code is held while master reset is low
    task automatic do_reset(input logic [2:0] c);
        sys_rst_i = 1'h1;
        mrs_n = 1'h0;
        code = c;
        repeat (16) @(negedge sys_clk_i);
        sys_rst_i = 1'h0;
        repeat (8) @(negedge sys_clk_i);
        mrs_n = 1'h1;
    endtask
    // bounded wait; release latency through the filter is not exact
    task automatic wait_oe();
        int i;
        i = 0;
        while (oe !== 1'h1 && i < 30) begin
            @(negedge sys_clk_i);
            i++;
        end
        check(32'(oe), 32'h1);
    endtask
    // four words from the current cycle: {oe, sync, token, word}
    task automatic walk(input logic chain);
        int k;
        for (k = 0; k < 4; k++) begin
            check(32'({oe, sync, tok_out, bus}),
                32'({1'h1, k == 0, chain && k == 3, WORDS_V[8*k +: 8]}));
            @(negedge sys_clk_i);
        end
    endtask
    task automatic complete_run();
        if (n_fail == 0 && n_checks > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////
    // lone polled device: words wrap, no token, bus dropped when polling stops
    task automatic lone_mode();
        exp_mode = 1'h0;
        polled = 1'h1;
        do_reset(3'h0);
        wait_oe();
        walk(1'h0);
        walk(1'h0);
        polled = 1'h0;
        repeat (2) @(negedge sys_clk_i);
        check(32'({oe, tok_out}), 32'h0);
    endtask
    // master starts the ring, hands off once, takes it back from the neighbour
    task automatic chain_ring(input logic [3:0] h);
        int i;
        exp_mode = 1'h1;
        polled = 1'h1;
        hold = h;
        do_reset(3'h0);
        wait_oe();
        walk(1'h1);
        check(32'({oe, tok_out}), 32'h0);
        i = 0;
        while (tok_in !== 1'h1 && i < 20) begin
            @(negedge sys_clk_i);
            i++;
        end
        check(32'({tok_in, oe}), 32'h2);
        @(negedge sys_clk_i);
        walk(1'h1);
    endtask
    // every device code on both buses; a matching select without enable misses
    task automatic select_codes();
        int c;
        for (c = 0; c < 8; c++) begin
            w_sel = {c[2:0], 5'h13};
            r_sel = {3'(7 - c), 5'h0A};
            we = 1'h1;
            re = 1'h1;
            @(negedge sys_clk_i);
            check(32'({w_hit, w_q}), 32'({c == 5, 5'h13}));
            check(32'({r_hit, r_q}), 32'({7 - c == 5, 5'h0A}));
        end
        w_sel = 8'hB1;
        we = 1'h0;
        re = 1'h0;
        @(negedge sys_clk_i);
        check(32'({w_hit, r_hit, w_q}), 32'h11);
    endtask
    // non-master waits for a token; a second token while driving is ignored
    task automatic slave_ring();
        int i;
        exp_mode = 1'h1;
        polled = 1'h1;
        do_reset(3'h5);
        for (i = 0; i < 12; i++) begin
            @(negedge sys_clk_i);
            check(32'(oe), 32'h0);
        end
        // code pins move after master reset; selection must still follow code 5
        code = 3'h2;
        select_codes();
        inject = 1'h1;
        repeat (2) @(negedge sys_clk_i);
        inject = 1'h0;
        wait_oe();
        walk(1'h1);
    endtask
    ////////////////////////////////////////////////////////////////
    // no serial setup is modelled; the code 000 master needs none after the others
    initial begin
        lone_mode();
        chain_ring(4'h1);
        chain_ring(4'h6);
        slave_ring();
        complete_run();
    end
    // watchdog well beyond the few hundred cycles the scenarios need
    initial begin
        #(CLK_PERIOD_NS * 3000);
        n_fail++;
        complete_run();
    end
endmodule
`default_nettype wire
